// ---- rtl/lsc_pkg.sv ----
// Constants, register map and types for the LIN sync control block
//
// Notes on behaviour
// - Control bit 11 high blocks the break compare interrupt; low lets it through.
// - Control bit 10 high blocks the break error interrupt; low lets it through.
// - Control bit 9 low ties transceiver transmit and receive to the UART.
// - Control bit 9 high routes pin 7 to transmit, receive to pin 8.
// - Control bit 8 high holds UART receive high until break and sync seen.
// - Control bit 8 low passes bus receive data to the UART throughout the frame.
// - Stop type low stops the sync timer on the counted falling edge.
// - Stop type high stops the sync timer on the counted rising edge.
// - Stop condition interrupts only while control bit 4 is high.
// - Start condition interrupts only while control bit 3 is high.
// - Break falling edge is edge one; defaults start at two, stop at three.
// - Break timer reaching compare value flags a valid break; compare defaults 0x47.
// - Break timer overflow before the rising edge flags a break field error.
package lsc_pkg;
  localparam int          SYS_HZ       = 25_000_000;
  localparam int          LP_HZ        = 131_000;
  localparam int          SYNC_HZ      = 5_000_000;
  localparam int          LP_DIV       = (SYS_HZ + LP_HZ / 2) / LP_HZ;
  localparam int          SYNC_DIV     = SYS_HZ / SYNC_HZ;
  localparam int          RST_NS       = 15_000;
  localparam int          RST_CYC      = (RST_NS * (SYS_HZ / 1_000_000) + 999) / 1000;

  localparam logic [7:0]  OFS_CTL0     = 8'h00;
  localparam logic [7:0]  OFS_EDGE     = 8'h04;
  localparam logic [7:0]  OFS_STAT     = 8'h08;
  localparam logic [7:0]  OFS_BRK      = 8'h0C;
  localparam logic [7:0]  OFS_SYNC     = 8'h10;
  localparam logic [7:0]  OFS_MASK     = 8'h14;

  localparam logic [15:0] CTL_WMASK    = 16'h0F9F;
  localparam logic [15:0] CTL_RST      = 16'h0000;
  localparam logic [7:0]  EDGE_RST     = 8'h32;
  localparam logic [11:0] BRK_CMP_RST  = 12'h047;
  localparam logic [5:0]  MASK_RST     = 6'h00;

  localparam int          CB_RESET     = 0;
  localparam int          CB_ECLR      = 1;
  localparam int          CB_SYNC_EN   = 2;
  localparam int          CB_START_IE  = 3;
  localparam int          CB_STOP_IE   = 4;
  localparam int          CB_STOP_RISE = 7;
  localparam int          CB_GATE      = 8;
  localparam int          CB_TEST      = 9;
  localparam int          CB_ERR_DIS   = 10;
  localparam int          CB_CMP_DIS   = 11;

  localparam int          SB_BRK       = 0;
  localparam int          SB_START     = 1;
  localparam int          SB_STOP      = 2;
  localparam int          SB_ERR       = 4;
  localparam int          SB_RSTDONE   = 5;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BREAK = 2'b01,
    ST_SYNC  = 2'b10,
    ST_DONE  = 2'b11
  } lsc_state_e;
endpackage

// ---- rtl/lsc_sync_ctrl.sv ----
// LIN hardware sync unit: control word, break and sync timing, pin routing
`timescale 1ns/1ps
`default_nettype none
module lsc_sync_ctrl
  import lsc_pkg::*;
#(
  parameter int LP_DIV_P  = LP_DIV,
  parameter int SYNC_DIV_P = SYNC_DIV
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  output logic             IRQ_O,
  input  wire logic        LIN_RXD_I,
  output logic             XCVR_TXD_O,
  input  wire logic        UART_TXD_I,
  output logic             UART_RXD_O,
  input  wire logic        GPIO7_I,
  output logic             GPIO8_O
);

  if (LP_DIV_P < 1 || LP_DIV_P > 65535 || SYNC_DIV_P < 1 || SYNC_DIV_P > 65535) begin : g_chk
    $error("lsc_sync_ctrl: tick dividers out of range");
  end

  logic [15:0] ctl_r;
  logic [7:0]  edge_r;
  logic [11:0] brk_cmp_r;
  logic [5:0]  mask_r;
  logic [5:0]  status_r;
  logic [5:0]  status_set;
  logic [5:0]  irq_en;
  logic [11:0] brk_cnt_r;
  logic [15:0] sync_cnt_r;
  logic [15:0] lp_div_r;
  logic [15:0] sy_div_r;
  logic [8:0]  rst_cnt_r;
  logic [3:0]  fall_cnt_r;
  logic [3:0]  rise_cnt_r;
  logic        run_r;
  logic        rx_prev_r;
  lsc_state_e  state_r;

  logic wr_ctl, rd_stat, rd_brk;
  logic fall_edge, rise_edge, lp_tick, sy_tick, hold;
  logic brk_hit, brk_ovf, start_hit, stop_hit, rst_done;

  assign wr_ctl    = WR_I && (ADDR_I == OFS_CTL0);
  assign rd_stat   = RD_I && (ADDR_I == OFS_STAT);
  assign rd_brk    = RD_I && (ADDR_I == OFS_BRK);
  assign fall_edge = rx_prev_r && !LIN_RXD_I;
  assign rise_edge = !rx_prev_r && LIN_RXD_I;
  assign lp_tick   = (lp_div_r == 16'(LP_DIV_P - 1));
  assign sy_tick   = (sy_div_r == 16'(SYNC_DIV_P - 1));
  assign hold      = ctl_r[CB_RESET] || ctl_r[CB_ECLR] || !ctl_r[CB_SYNC_EN];

  assign brk_hit   = (state_r == ST_BREAK) && lp_tick && ((brk_cnt_r + 12'h001) == brk_cmp_r);
  assign brk_ovf   = (state_r == ST_BREAK) && lp_tick && (brk_cnt_r == 12'hFFF);
  assign start_hit = (state_r == ST_SYNC) && !run_r && fall_edge
                     && ((fall_cnt_r + 4'h1) == edge_r[3:0]);
  assign stop_hit  = (state_r == ST_SYNC) && run_r
                     && (ctl_r[CB_STOP_RISE]
                         ? (rise_edge && ((rise_cnt_r + 4'h1) == edge_r[7:4]))
                         : (fall_edge && ((fall_cnt_r + 4'h1) == edge_r[7:4])));
  assign rst_done  = ctl_r[CB_RESET] && (rst_cnt_r == 9'(RST_CYC - 1));

  assign status_set = {rst_done, brk_ovf, 1'b0, stop_hit, start_hit, brk_hit};
  assign irq_en = {1'b1, !ctl_r[CB_ERR_DIS], 1'b0, ctl_r[CB_STOP_IE],
                   ctl_r[CB_START_IE], !ctl_r[CB_CMP_DIS]};

  // Control word; reset bit clears itself after the delay
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctl_r <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_r <= WDATA_I & CTL_WMASK;
    end else if (rst_done) begin
      ctl_r[CB_RESET] <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_cnt_r <= 9'h000;
    end else if (ctl_r[CB_RESET] && !rst_done) begin
      rst_cnt_r <= rst_cnt_r + 9'h001;
    end else begin
      rst_cnt_r <= 9'h000;
    end
  end

  // Other software registers; the reset bit restores edge and compare but not the mask
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      edge_r    <= EDGE_RST;
      brk_cmp_r <= BRK_CMP_RST;
      mask_r    <= MASK_RST;
    end else if (ctl_r[CB_RESET]) begin
      edge_r    <= EDGE_RST;
      brk_cmp_r <= BRK_CMP_RST;
    end else if (WR_I) begin
      if (ADDR_I == OFS_EDGE) begin
        edge_r <= WDATA_I[7:0];
      end
      if (ADDR_I == OFS_BRK) begin
        brk_cmp_r <= WDATA_I[11:0];
      end
      if (ADDR_I == OFS_MASK) begin
        mask_r <= WDATA_I[5:0];
      end
    end
  end

  // sticky flags, set wins over read clear
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      status_r <= 6'h00;
    end else if (rd_stat) begin
      status_r <= status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status_r & mask_r & irq_en);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        OFS_CTL0: RDATA_O <= ctl_r;
        OFS_EDGE: RDATA_O <= {8'h00, edge_r};
        OFS_STAT: RDATA_O <= {10'h000, status_r};
        OFS_BRK:  RDATA_O <= {4'h0, brk_cnt_r};
        OFS_SYNC: RDATA_O <= sync_cnt_r;
        OFS_MASK: RDATA_O <= {10'h000, mask_r};
        default:  RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

  // Free tick dividers standing in for the low power and 5 MHz clocks
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lp_div_r <= 16'h0000;
      sy_div_r <= 16'h0000;
    end else begin
      lp_div_r <= lp_tick ? 16'h0000 : lp_div_r + 16'h0001;
      sy_div_r <= sy_tick ? 16'h0000 : sy_div_r + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= LIN_RXD_I;
    end
  end

  // Break timer; a read or a falling edge restarts it
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      brk_cnt_r <= 12'h000;
    end else if (ctl_r[CB_RESET] || fall_edge || rd_brk) begin
      brk_cnt_r <= 12'h000;
    end else if (state_r == ST_BREAK && lp_tick) begin
      brk_cnt_r <= brk_cnt_r + 12'h001;
    end
  end

  // Frame sequencer; DONE waits for a software re-arm
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
    end else if (hold) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (fall_edge) begin
            state_r <= ST_BREAK;
          end
        end
        ST_BREAK: begin
          if (brk_ovf) begin
            state_r <= ST_IDLE;
          end else if (rise_edge) begin
            state_r <= status_r[SB_BRK] ? ST_SYNC : ST_IDLE;
          end
        end
        ST_SYNC: begin
          if (stop_hit) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_DONE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // break edge counts as the first falling edge
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fall_cnt_r <= 4'h0;
      rise_cnt_r <= 4'h0;
    end else if (hold) begin
      fall_cnt_r <= 4'h0;
      rise_cnt_r <= 4'h0;
    end else if (state_r == ST_IDLE && fall_edge) begin
      fall_cnt_r <= 4'h1;
      rise_cnt_r <= 4'h0;
    end else if (state_r == ST_SYNC || state_r == ST_BREAK) begin
      if (fall_edge) begin
        fall_cnt_r <= fall_cnt_r + 4'h1;
      end
      if (rise_edge) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end

  // Sync timer keeps its stop value for software
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      run_r      <= 1'b0;
      sync_cnt_r <= 16'h0000;
    end else if (ctl_r[CB_RESET]) begin
      run_r      <= 1'b0;
      sync_cnt_r <= 16'h0000;
    end else if (start_hit) begin
      run_r      <= 1'b1;
      sync_cnt_r <= 16'h0000;
    end else if (stop_hit || hold) begin
      run_r <= 1'b0;
    end else if (run_r && sy_tick) begin
      sync_cnt_r <= sync_cnt_r + 16'h0001;
    end
  end

  // Pin routing, registered so outputs come from flops
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      XCVR_TXD_O <= 1'b1;
      UART_RXD_O <= 1'b1;
      GPIO8_O    <= 1'b1;
    end else if (ctl_r[CB_TEST]) begin
      XCVR_TXD_O <= GPIO7_I;
      GPIO8_O    <= LIN_RXD_I;
      UART_RXD_O <= 1'b1;
    end else begin
      XCVR_TXD_O <= UART_TXD_I;
      GPIO8_O    <= 1'b1;
      UART_RXD_O <= (ctl_r[CB_GATE] && state_r != ST_DONE) ? 1'b1 : LIN_RXD_I;
    end
  end

  a_cmp_irq_on: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    ($rose(status_r[SB_BRK]) && !ctl_r[CB_CMP_DIS] && mask_r[SB_BRK]) |=> IRQ_O)
    else $error("break compare interrupt not raised");
  a_cmp_irq_off: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (status_r == 6'h01 && ctl_r[CB_CMP_DIS] && $stable(ctl_r)) |=> !IRQ_O)
    else $error("disabled break compare raised interrupt");
  a_err_irq_on: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    ($rose(status_r[SB_ERR]) && !ctl_r[CB_ERR_DIS] && mask_r[SB_ERR]) |=> IRQ_O)
    else $error("break error interrupt not raised");
  a_uart_path: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    !ctl_r[CB_TEST] |=> (XCVR_TXD_O == $past(UART_TXD_I)))
    else $error("transmit not from UART");
  a_test_path: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    ctl_r[CB_TEST] |=> (XCVR_TXD_O == $past(GPIO7_I) && GPIO8_O == $past(LIN_RXD_I)))
    else $error("test mode routing wrong");
  a_rx_gated: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (ctl_r[CB_GATE] && state_r != ST_DONE) |=> UART_RXD_O)
    else $error("UART receive not gated high");
  a_rx_pass: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (!ctl_r[CB_GATE] && !ctl_r[CB_TEST]) |=> (UART_RXD_O == $past(LIN_RXD_I)))
    else $error("UART receive not passed");
  a_stop_fall: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (state_r == ST_SYNC && run_r && !ctl_r[CB_STOP_RISE] && fall_edge && !hold
     && (fall_cnt_r + 4'h1) == edge_r[7:4]) |=> (state_r == ST_DONE && !run_r))
    else $error("sync timer missed falling stop edge");
  a_stop_rise: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (state_r == ST_SYNC && run_r && ctl_r[CB_STOP_RISE] && rise_edge && !hold
     && (rise_cnt_r + 4'h1) == edge_r[7:4]) |=> (state_r == ST_DONE && !run_r))
    else $error("sync timer missed rising stop edge");
  a_stop_irq: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    ($rose(status_r[SB_STOP]) && ctl_r[CB_STOP_IE] && mask_r[SB_STOP]) |=> IRQ_O)
    else $error("stop interrupt not raised");
  a_start_irq: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (status_r[SB_START] && mask_r == 6'h02 && !ctl_r[CB_START_IE]) |=> !IRQ_O)
    else $error("disabled start raised interrupt");
  a_brk_valid: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    brk_hit |=> status_r[SB_BRK])
    else $error("valid break not flagged");
  a_brk_ovf: assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
    (state_r == ST_BREAK && lp_tick && brk_cnt_r == 12'hFFF && !hold)
    |=> (status_r[SB_ERR] && state_r == ST_IDLE))
    else $error("break overflow not flagged");

endmodule
`default_nettype wire

// ---- tb/lsc_lin_master.sv ----
// Behavioural LIN master: break, delimiter and sync byte on the bus line
`timescale 1ns/1ps
`default_nettype none
module lsc_lin_master #(
  parameter int BIT_CYC = 20
) (
  input  wire logic clk_i,
  output var logic  rxd_o
);
  // Bus has a pull-up, so released means recessive high
  initial rxd_o = 1'b1;

  task automatic drive(input logic v, input int n);
    rxd_o <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic frame(input int brk);
    logic [9:0] b;
    b = {1'b1, 8'h55, 1'b0};
    drive(1'b0, brk);
    drive(1'b1, BIT_CYC);
    for (int i = 0; i < 10; i++) begin
      drive(b[i], BIT_CYC);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/lin_sync_control_upper_test.sv ----
// Self-checking bench for the LIN sync control block
`timescale 1ns/1ps
`default_nettype none
module lin_sync_control_upper_test;
  import lsc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        utx = 1'b1;
  logic        g7 = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdat;
  logic        irq;
  logic        xtx;
  logic        urx;
  logic        g8;
  wire logic   rx;
  int          bad_count = 0;
  int          checks = 0;

  always #20 clk = ~clk;

  lsc_lin_master #(.BIT_CYC(20)) MST (.clk_i(clk), .rxd_o(rx));

  // Short dividers keep break and overflow runs affordable
  lsc_sync_ctrl #(.LP_DIV_P(4), .SYNC_DIV_P(2)) DUT (
    .CLOCK_I(clk), .RESETN_I(rstn), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .IRQ_O(irq), .LIN_RXD_I(rx), .XCVR_TXD_O(xtx),
    .UART_TXD_I(utx), .UART_RXD_O(urx), .GPIO7_I(g7), .GPIO8_O(g8)
  );

  task automatic complete_run;
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h", $time, m, g);
    end
  endtask

  // Edge sampling latency may shift the count by one
  task automatic near(input logic [15:0] g, input int e, input string m);
    checks++;
    if ($isunknown(g) || !(int'(g) >= e - 1 && int'(g) <= e + 1)) begin
      bad_count++;
      $display("[FAIL] %0t %s got %0d", $time, m, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let an edge pass so the next call never re-raises the strobe in this step
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask

  // Clearing the word first re-arms the sequencer out of its done state
  task automatic setup(input logic [15:0] c, input logic [15:0] m);
    logic [15:0] v;
    wr_reg(OFS_CTL0, 16'h0000);
    wr_reg(OFS_BRK, 16'h0008);
    wr_reg(OFS_MASK, m);
    wr_reg(OFS_CTL0, c);
    rd_reg(OFS_STAT, v);
  endtask

  task automatic t_reset;
    logic [15:0] v;
    rd_reg(OFS_CTL0, v);
    chk(v, 16'h0000, "control reset");
    rd_reg(OFS_EDGE, v);
    chk(v, 16'h0032, "edge count reset");
    rd_reg(OFS_MASK, v);
    chk(v, 16'h0000, "mask reset");
    rd_reg(8'h3C, v);
    chk(v, 16'h0000, "unmapped read");
    chk(16'(urx), 16'h0001, "uart rx idle");
    chk(16'(g8), 16'h0001, "pin8 idle");
  endtask

  task automatic t_frame(input logic [15:0] c, input logic [15:0] m, input logic ei,
                         input int es);
    logic [15:0] v;
    setup(c, m);
    MST.frame(60);
    repeat (3) @(posedge clk);
    chk(16'(irq), 16'(ei), "irq after frame");
    rd_reg(OFS_SYNC, v);
    near(v, es, "sync timer stop");
    rd_reg(OFS_STAT, v);
    chk(v, 16'h0007, "frame status");
    repeat (2) @(posedge clk);
    chk(16'(irq), 16'h0000, "irq after status read");
  endtask

  task automatic t_gate;
    int low;
    low = 0;
    setup(16'h0184, 16'h0000);
    // Stop on the sixth rise, the end of the sync byte, so no low reaches the UART
    wr_reg(OFS_EDGE, 16'h0062);
    fork
      MST.frame(60);
      repeat (280) begin
        @(posedge clk);
        if (urx !== 1'b1) low++;
      end
    join
    chk(16'(low), 16'h0000, "uart rx gated in frame");
    MST.drive(1'b0, 3);
    chk(16'(urx), 16'h0000, "uart rx after sync");
    MST.drive(1'b1, 3);
    setup(16'h0004, 16'h0000);
    MST.drive(1'b0, 3);
    chk(16'(urx), 16'h0000, "uart rx ungated");
    MST.drive(1'b1, 3);
    chk(16'(urx), 16'h0001, "uart rx ungated high");
  endtask

  task automatic t_pins;
    setup(16'h0200, 16'h0000);
    g7 <= 1'b0;
    MST.drive(1'b0, 3);
    chk(16'(xtx), 16'h0000, "tx from pin7");
    chk(16'(g8), 16'h0000, "rx to pin8");
    chk(16'(urx), 16'h0001, "uart rx held in test");
    g7 <= 1'b1;
    MST.drive(1'b1, 3);
    chk(16'(xtx), 16'h0001, "tx from pin7 high");
    setup(16'h0000, 16'h0000);
    utx <= 1'b0;
    g7 <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(xtx), 16'h0000, "tx from uart");
    utx <= 1'b1;
    g7 <= 1'b0;
    repeat (3) @(posedge clk);
    chk(16'(xtx), 16'h0001, "tx from uart high");
    chk(16'(g8), 16'h0001, "pin8 idle normal");
    g7 <= 1'b1;
  endtask

  task automatic t_soft;
    logic [15:0] v;
    wr_reg(OFS_CTL0, 16'h0001);
    repeat (RST_CYC + 8) @(posedge clk);
    rd_reg(OFS_CTL0, v);
    chk(v, 16'h0000, "soft reset self clear");
    rd_reg(OFS_EDGE, v);
    chk(v, 16'(EDGE_RST), "edge count restored");
    rd_reg(OFS_STAT, v);
    chk(v, 16'h0020, "reset done flag");
  endtask

  task automatic t_err(input logic dis);
    logic [15:0] v;
    setup(dis ? 16'h0404 : 16'h0004, 16'h0010);
    MST.drive(1'b0, 16500);
    chk(16'(irq), 16'(!dis), "break error irq");
    MST.drive(1'b1, 5);
    rd_reg(OFS_STAT, v);
    chk(v, 16'h0011, "break error status");
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t run timed out", $time);
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_frame(16'h001C, 16'h003F, 1'b1, 20);
    t_frame(16'h001C, 16'h003F, 1'b1, 20);
    t_frame(16'h0804, 16'h003F, 1'b0, 20);
    t_frame(16'h0004, 16'h0001, 1'b1, 20);
    t_frame(16'h0014, 16'h0004, 1'b1, 20);
    t_frame(16'h000C, 16'h0002, 1'b1, 20);
    t_frame(16'h0004, 16'h0002, 1'b0, 20);
    t_frame(16'h0804, 16'h0006, 1'b0, 20);
    t_frame(16'h0094, 16'h0004, 1'b1, 30);
    t_gate();
    t_soft();
    t_pins();
    t_err(1'b1);
    t_err(1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
